// ==== rtl/sigmon_pkg.sv ====
package sigmon_pkg;
  // Widths of the data path and register fields.
  localparam int SAMPLE_W = 10;
  localparam int LIMIT_W = 13;
  localparam int DWELL_W = 16;
  localparam int DC_W = 14;
  localparam int DC_FRAC = 4;
  localparam int ACC_W = 40;
  localparam int PERIOD_W = 24;
  localparam int RESULT_W = 20;
  localparam int SQ_W = 2 * SAMPLE_W;
  localparam int SUM_W = SQ_W + 1 + PERIOD_W;
  localparam int ADDR_W = 9;
  localparam int WORD_W = 24;
  // Register byte addresses.
  localparam logic [ADDR_W-1:0] A_UPPER_LO = 9'h106;
  localparam logic [ADDR_W-1:0] A_UPPER_HI = 9'h107;
  localparam logic [ADDR_W-1:0] A_LOWER_LO = 9'h108;
  localparam logic [ADDR_W-1:0] A_LOWER_HI = 9'h109;
  localparam logic [ADDR_W-1:0] A_DWELL_LO = 9'h10a;
  localparam logic [ADDR_W-1:0] A_DWELL_HI = 9'h10b;
  localparam logic [ADDR_W-1:0] A_DCC = 9'h10c;
  localparam logic [ADDR_W-1:0] A_DCA_LO = 9'h10d;
  localparam logic [ADDR_W-1:0] A_DCA_HI = 9'h10e;
  localparam logic [ADDR_W-1:0] A_DCB_LO = 9'h10f;
  localparam logic [ADDR_W-1:0] A_DCB_HI = 9'h110;
  localparam logic [ADDR_W-1:0] A_SERC = 9'h111;
  localparam logic [ADDR_W-1:0] A_MONC = 9'h112;
  localparam logic [ADDR_W-1:0] A_PER0 = 9'h113;
  localparam logic [ADDR_W-1:0] A_PER1 = 9'h114;
  localparam logic [ADDR_W-1:0] A_PER2 = 9'h115;
  localparam logic [ADDR_W-1:0] A_RESA0 = 9'h116;
  localparam logic [ADDR_W-1:0] A_RESA1 = 9'h117;
  localparam logic [ADDR_W-1:0] A_RESA2 = 9'h118;
  localparam logic [ADDR_W-1:0] A_RESB0 = 9'h119;
  localparam logic [ADDR_W-1:0] A_RESB1 = 9'h11a;
  localparam logic [ADDR_W-1:0] A_RESB2 = 9'h11b;
  // Field positions.
  localparam int DCC_FREEZE = 6;
  localparam int DCC_PATH = 1;
  localparam int DCC_MON = 0;
  localparam int SER_RMS = 6;
  localparam int SER_PEAK = 5;
  localparam int SER_THR = 4;
  localparam int SER_SLEEP = 1;
  localparam int SER_EN = 0;
  localparam int MON_CPLX = 7;
  localparam int MON_MS = 3;
  localparam int MON_EN = 0;
  // Writable bit masks and reset values.
  localparam logic [7:0] DCC_MASK = 8'h7f;
  localparam logic [7:0] SERC_MASK = 8'h7f;
  localparam logic [7:0] MONC_MASK = 8'h8f;
  localparam logic [7:0] SERC_RST = 8'h04;
  localparam logic [7:0] MONC_RST = 8'h00;
  localparam logic [PERIOD_W-1:0] PERIOD_RST = 24'h00_0040;
  localparam logic [PERIOD_W-1:0] PERIOD_ONE = 24'h00_0001;
  // Offset averaging: shift is k plus this base, k capped.
  localparam logic [3:0] DC_BW_MAX = 4'hd;
  localparam logic [5:0] DC_SHIFT_BASE = 6'h0e;
  // Mode codes, clock divide codes and half-period counts.
  localparam logic [1:0] MODE_POWER = 2'h0;
  localparam logic [1:0] MODE_PEAK = 2'h1;
  localparam logic [1:0] DIV_CODE_4 = 2'h2;
  localparam logic [1:0] DIV_CODE_8 = 2'h3;
  localparam logic [2:0] HALF_2 = 3'h0;
  localparam logic [2:0] HALF_4 = 3'h1;
  localparam logic [2:0] HALF_8 = 3'h3;
  // Serial word kinds and their lengths in bits.
  typedef enum logic [1:0] {KIND_RMS, KIND_PEAK, KIND_THR} kind_e;
  localparam logic [4:0] LEN_LONG = 5'h14;
  localparam logic [4:0] LEN_SHORT = 5'h0a;
  localparam logic [2:0] LAST_IDX = 3'h5;
  localparam logic [2:0] CH_B_IDX = 3'h3;
endpackage : sigmon_pkg

// ==== rtl/word_stream_if.sv ====
`timescale 1ns/100ps
interface word_stream_if #(parameter int W = 8);
  logic valid;
  logic ready;
  logic [W-1:0] data;
  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface : word_stream_if

// ==== rtl/stream_fifo.sv ====
`timescale 1ns/100ps
module stream_fifo #(
  parameter int WIDTH = 24,
  parameter int DEPTH = 16
) (
  // Clock and reset.
  input wire logic mclk,
  input wire logic rst_n,
  // Fill side.
  word_stream_if.snk wr,
  // Drain side.
  word_stream_if.src rd
);
  localparam int AW = $clog2(DEPTH);
  if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_chk
    $error("FIFO depth must be a power of two of at least two.");
  end
  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW:0] wp;
    logic [AW:0] rp;
  } fifo_s;
  fifo_s s_q, s_d;
  logic full;
  logic empty;
  // Extra pointer bit tells a full ring from an empty one.
  assign full = (s_q.wp[AW] != s_q.rp[AW]) &&
                (s_q.wp[AW-1:0] == s_q.rp[AW-1:0]);
  assign empty = (s_q.wp == s_q.rp);
  assign wr.ready = !full;
  assign rd.valid = !empty;
  assign rd.data = s_q.mem[s_q.rp[AW-1:0]];
  // Push and pop may happen in the same cycle.
  always_comb begin
    s_d = s_q;
    if (wr.valid && !full) begin
      s_d.mem[s_q.wp[AW-1:0]] = wr.data;
      s_d.wp = s_q.wp + 1'b1;
    end
    if (rd.ready && !empty) begin
      s_d.rp = s_q.rp + 1'b1;
    end
  end
  // State register.
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end
endmodule : stream_fifo

// ==== rtl/serial_shifter.sv ====
`timescale 1ns/100ps
module serial_shifter
  import sigmon_pkg::*;
(
  // Clock and reset.
  input wire logic mclk,
  input wire logic rst_n,
  // Words to send.
  word_stream_if.snk src,
  // Controls.
  input wire logic enable,
  input wire logic sleep,
  input wire logic [1:0] div_code,
  // Serial pins.
  output logic sclk,
  output logic sdata,
  output logic frame
);
  typedef struct packed {
    logic [2:0] cnt;
    logic sclk;
    logic [RESULT_W-1:0] sh;
    logic [4:0] left;
    logic busy;
    logic frame;
  } shift_s;
  shift_s s_q, s_d;
  logic [2:0] half;
  logic idle_sleep;
  logic slot;
  logic take;
  assign half = (div_code == DIV_CODE_8) ? HALF_8 :
                (div_code == DIV_CODE_4) ? HALF_4 : HALF_2;
  assign idle_sleep = !s_q.busy && sleep;
  // Data moves on falling clock edges so the receiver samples on rising.
  assign slot = idle_sleep || (s_q.cnt == half && s_q.sclk);
  assign take = slot && (!s_q.busy || s_q.left <= 5'h01) &&
                src.valid && enable;
  assign src.ready = take;
  assign sclk = s_q.sclk;
  assign sdata = s_q.sh[RESULT_W-1];
  assign frame = s_q.frame;
  // Bit advance, word load and clock generation.
  always_comb begin
    s_d = s_q;
    if (slot) begin
      if (s_q.busy && s_q.left > 5'h01) begin
        s_d.sh = {s_q.sh[RESULT_W-2:0], 1'b0};
        s_d.left = s_q.left - 5'h01;
        s_d.frame = 1'b0;
      end else begin
        s_d.busy = 1'b0;
        s_d.frame = 1'b0;
        // [RL12] Start only enabled.
        if (take) begin
          s_d.busy = 1'b1;
          s_d.frame = 1'b1;
          if (src.data[WORD_W-1:WORD_W-2] == KIND_RMS) begin
            s_d.sh = src.data[RESULT_W-1:0];
            s_d.left = LEN_LONG;
          end else begin
            s_d.sh = {src.data[SAMPLE_W-1:0], {SAMPLE_W{1'b0}}};
            s_d.left = LEN_SHORT;
          end
        end
      end
    end
    // [RL11] Sleep holds low.
    if (idle_sleep) begin
      s_d.sclk = 1'b0;
      s_d.cnt = '0;
    // [RL10] Clock divide.
    end else if (s_q.cnt == half) begin
      s_d.cnt = '0;
      s_d.sclk = !s_q.sclk;
    end else begin
      s_d.cnt = s_q.cnt + 3'h1;
    end
  end
  // State register.
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end
endmodule : serial_shifter

// ==== rtl/adc_signal_monitor.sv ====
`timescale 1ns/100ps
// Function
// [RL1] Set fine-over when sample magnitude exceeds the 13-bit upper limit.
// [RL2] Set fine-below when sample magnitude is under the 13-bit lower limit.
// [RL3] Raise gain flag after staying below lower limit for dwell cycles.
// [RL4] Freeze bit holds the offset estimate the monitor uses.
// [RL5] Averaging shift is k plus fourteen; codes above thirteen act as 13.
// [RL6] Path bit subtracts the offset estimate from output samples.
// [RL7] Monitor bit removes the offset before measurements.
// [RL8] Offset estimate readable per channel as 14 bits over two bytes.
// [RL9] Serial output carries only enabled measurement kinds.
// [RL10] Serial clock divides by 2, 4 or 8 per code.
// [RL11] Sleep bit holds serial clock low while nothing to send.
// [RL12] Serial shifting starts only while serial enable is set.
// [RL13] Complex mode reports root of I squared plus Q squared.
// [RL14] Select bit chooses root-mean-square or mean-square power.
// [RL15] Mode field picks power, peak or threshold crossing results.
// [RL16] Measurements run only while monitor enable is high.
// [RL17] Period is 24 bits, resets to 64; software uses at least 128.
// [RL18] Twenty-bit result per channel readable over three bytes.
// [RL19] Sync restarts the period only when both sync enables are high.
// [RL20] Period end updates results and restarts accumulation.
// [RL21] Peak mode reports largest magnitude in the period.
module adc_signal_monitor
  import sigmon_pkg::*;
#(
  parameter int FIFO_DEPTH = 16
) (
  // Clock and reset.
  input wire logic mclk,
  input wire logic rst_n,
  // Converter samples, twos complement.
  input wire logic [SAMPLE_W-1:0] sample_a,
  input wire logic [SAMPLE_W-1:0] sample_b,
  // External sync and its enables.
  input wire logic sync_pulse,
  input wire logic monitor_sync_en,
  input wire logic master_sync_en,
  // Byte register port.
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [ADDR_W-1:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  // Sample path, offset removed only when the path bit is set.
  output logic [SAMPLE_W-1:0] data_a,
  output logic [SAMPLE_W-1:0] data_b,
  // Level indications, bit 0 is channel A.
  output logic [1:0] fine_over_flag,
  output logic [1:0] fine_below_flag,
  output logic [1:0] gain_raise_flag,
  // Serial monitor output.
  output logic monitor_serial_clock,
  output logic monitor_serial_output,
  output logic monitor_serial_frame
);
  if (FIFO_DEPTH < 2 || (FIFO_DEPTH & (FIFO_DEPTH - 1)) != 0) begin : g_chk
    $error("FIFO_DEPTH must be a power of two of at least two.");
  end

  typedef struct packed {
    logic [LIMIT_W-1:0] upper, lower;
    logic [DWELL_W-1:0] dwell;
    logic [7:0] dcc, serc, monc, rdata;
    logic [PERIOD_W-1:0] period, cnt;
    logic [1:0][ACC_W-1:0] acc;
    logic [1:0][DC_W-1:0] dc;
    logic [1:0][SAMPLE_W-1:0] out, peak, thr, peak_snap, thr_snap;
    logic [1:0][RESULT_W-1:0] pow_snap, result;
    logic [1:0][SUM_W-1:0] sum;
    logic [1:0][DWELL_W-1:0] below_cnt;
    logic [1:0] over, below, raise;
    logic [2:0] idx;
    logic pushing;
  } state_s;
  state_s s_q, s_d;
  logic [1:0][SAMPLE_W-1:0] raw, corr, mag_raw, mag_mon;
  logic [1:0][SQ_W-1:0] sq;
  logic [SQ_W:0] sq_cplx;
  logic [3:0] bw_k;
  logic [5:0] acc_sh;
  logic [4:0] per_log;
  logic sync_go, last, push_en, push_ch;
  logic [7:0] rd_val;
  kind_e push_kind;
  logic [RESULT_W-1:0] push_val;
  word_stream_if #(.W(WORD_W)) fill_if ();
  word_stream_if #(.W(WORD_W)) drain_if ();

  // Magnitude of a twos complement sample; the most negative code
  // still fits because the result is unsigned.
  function automatic logic [SAMPLE_W-1:0] magnitude(
    input logic [SAMPLE_W-1:0] x
  );
    return x[SAMPLE_W-1] ? SAMPLE_W'(-x) : x;
  endfunction : magnitude
  // Clip an 11-bit difference back to the sample range.
  function automatic logic [SAMPLE_W-1:0] clip(input logic [SAMPLE_W:0] d);
    if (d[SAMPLE_W] != d[SAMPLE_W-1]) begin
      return {d[SAMPLE_W], {(SAMPLE_W-1){!d[SAMPLE_W]}}};
    end
    return d[SAMPLE_W-1:0];
  endfunction : clip
  // Bitwise integer square root, one bit per loop pass.
  function automatic logic [SAMPLE_W-1:0] isqrt(
    input logic [RESULT_W-1:0] v
  );
    logic [SAMPLE_W-1:0] r;
    logic [SAMPLE_W-1:0] t;
    r = '0;
    for (int b = SAMPLE_W - 1; b >= 0; b--) begin
      t = r | SAMPLE_W'(1 << b);
      if (RESULT_W'(t) * RESULT_W'(t) <= v) begin
        r = t;
      end
    end
    return r;
  endfunction : isqrt
  // Index of the highest set bit of the period.
  function automatic logic [4:0] top_bit(input logic [PERIOD_W-1:0] p);
    logic [4:0] r;
    r = '0;
    for (int i = 0; i < PERIOD_W; i++) begin
      if (p[i]) begin
        r = 5'(i);
      end
    end
    return r;
  endfunction : top_bit
  assign raw[0] = sample_a;
  assign raw[1] = sample_b;

  // Per-channel corrected sample, magnitudes and square.
  for (genvar c = 0; c < 2; c++) begin : g_ch
    logic [SAMPLE_W:0] diff;
    logic [SAMPLE_W-1:0] mon_x;
    logic signed [SQ_W-1:0] prod;
    assign diff = {raw[c][SAMPLE_W-1], raw[c]} -
                  {s_q.dc[c][DC_W-1], s_q.dc[c][DC_W-1:DC_FRAC]};
    assign corr[c] = clip(diff);
    // [RL7] Monitor offset removal.
    assign mon_x = s_q.dcc[DCC_MON] ? corr[c] : raw[c];
    assign mag_raw[c] = magnitude(raw[c]);
    assign mag_mon[c] = magnitude(mon_x);
    assign prod = $signed(mon_x) * $signed(mon_x);
    assign sq[c] = prod;
  end

  assign sq_cplx = {1'b0, sq[0]} + {1'b0, sq[1]};
  // [RL5] Bandwidth code cap.
  assign bw_k = (s_q.dcc[5:2] > DC_BW_MAX) ? DC_BW_MAX : s_q.dcc[5:2];
  assign acc_sh = {2'b00, bw_k} + DC_SHIFT_BASE;
  // Mean square divides by the largest power of two in the period,
  // which is exact for power-of-two periods and saves a divider.
  assign per_log = top_bit(s_q.period);
  // [RL19] Gated sync.
  assign sync_go = sync_pulse && monitor_sync_en && master_sync_en;
  assign last = (s_q.period <= PERIOD_ONE) ||
                (s_q.cnt >= s_q.period - PERIOD_ONE);

  // Word selection for the serial queue: three kinds per channel.
  assign push_ch = (s_q.idx >= CH_B_IDX);
  assign push_kind = kind_e'(push_ch ? s_q.idx - CH_B_IDX : s_q.idx);
  always_comb begin
    push_en = 1'b0;
    push_val = '0;
    unique case (push_kind)
      KIND_RMS: begin
        push_en = s_q.serc[SER_RMS];
        push_val = s_q.pow_snap[push_ch];
      end
      KIND_PEAK: begin
        push_en = s_q.serc[SER_PEAK];
        push_val = RESULT_W'(s_q.peak_snap[push_ch]);
      end
      KIND_THR: begin
        push_en = s_q.serc[SER_THR];
        push_val = RESULT_W'(s_q.thr_snap[push_ch]);
      end
      default: ;
    endcase
  end
  // [RL9] Enabled kinds only.
  assign fill_if.valid = s_q.pushing && push_en;
  assign fill_if.data = {push_kind, push_ch, 1'b0, push_val};

  // Register read decode; unmapped addresses read as zero.
  always_comb begin
    rd_val = '0;
    case (reg_addr)
      A_UPPER_LO: rd_val = s_q.upper[7:0];
      A_UPPER_HI: rd_val = 8'(s_q.upper[LIMIT_W-1:8]);
      A_LOWER_LO: rd_val = s_q.lower[7:0];
      A_LOWER_HI: rd_val = 8'(s_q.lower[LIMIT_W-1:8]);
      A_DWELL_LO: rd_val = s_q.dwell[7:0];
      A_DWELL_HI: rd_val = s_q.dwell[15:8];
      A_DCC: rd_val = s_q.dcc;
      // [RL8] Offset readback.
      A_DCA_LO: rd_val = s_q.dc[0][7:0];
      A_DCA_HI: rd_val = 8'(s_q.dc[0][DC_W-1:8]);
      A_DCB_LO: rd_val = s_q.dc[1][7:0];
      A_DCB_HI: rd_val = 8'(s_q.dc[1][DC_W-1:8]);
      A_SERC: rd_val = s_q.serc;
      A_MONC: rd_val = s_q.monc;
      A_PER0: rd_val = s_q.period[7:0];
      A_PER1: rd_val = s_q.period[15:8];
      A_PER2: rd_val = s_q.period[23:16];
      // [RL18] Result readback.
      A_RESA0: rd_val = s_q.result[0][7:0];
      A_RESA1: rd_val = s_q.result[0][15:8];
      A_RESA2: rd_val = 8'(s_q.result[0][RESULT_W-1:16]);
      A_RESB0: rd_val = s_q.result[1][7:0];
      A_RESB1: rd_val = s_q.result[1][15:8];
      A_RESB2: rd_val = 8'(s_q.result[1][RESULT_W-1:16]);
      default: rd_val = '0;
    endcase
  end

  // Next-state logic for registers, offset estimate, flags and monitor.
  always_comb begin
    logic [ACC_W-1:0] acc_n;
    logic [SQ_W:0] pw;
    logic [SUM_W-1:0] sum_f, scaled;
    logic [RESULT_W-1:0] ms, pow;
    logic [SAMPLE_W-1:0] peak_f, thr_f;
    logic below_now;
    acc_n = '0;
    pw = '0;
    sum_f = '0;
    scaled = '0;
    ms = '0;
    pow = '0;
    peak_f = '0;
    thr_f = '0;
    below_now = 1'b0;
    s_d = s_q;
    if (reg_rd) begin
      s_d.rdata = rd_val;
    end
    // Software writes; reserved bits are dropped.
    if (reg_wr) begin
      case (reg_addr)
        A_UPPER_LO: s_d.upper[7:0] = reg_wdata;
        A_UPPER_HI: s_d.upper[LIMIT_W-1:8] = reg_wdata[4:0];
        A_LOWER_LO: s_d.lower[7:0] = reg_wdata;
        A_LOWER_HI: s_d.lower[LIMIT_W-1:8] = reg_wdata[4:0];
        A_DWELL_LO: s_d.dwell[7:0] = reg_wdata;
        A_DWELL_HI: s_d.dwell[15:8] = reg_wdata;
        A_DCC: s_d.dcc = reg_wdata & DCC_MASK;
        A_SERC: s_d.serc = reg_wdata & SERC_MASK;
        A_MONC: s_d.monc = reg_wdata & MONC_MASK;
        // [RL17] Period bytes.
        A_PER0: s_d.period[7:0] = reg_wdata;
        A_PER1: s_d.period[15:8] = reg_wdata;
        A_PER2: s_d.period[23:16] = reg_wdata;
        default: ;
      endcase
    end
    for (int c = 0; c < 2; c++) begin
      // [RL5] Leaky average.
      acc_n = s_q.acc[c] + ACC_W'($signed(raw[c])) -
              ACC_W'($signed(s_q.acc[c]) >>> acc_sh);
      s_d.acc[c] = acc_n;
      // [RL4] Freeze holds estimate.
      if (!s_q.dcc[DCC_FREEZE]) begin
        s_d.dc[c] = DC_W'($signed(acc_n) >>> (acc_sh - 6'(DC_FRAC)));
      end
      // [RL6] Path correction.
      s_d.out[c] = s_q.dcc[DCC_PATH] ? corr[c] : raw[c];
      // [RL1] Fine over.
      s_d.over[c] = LIMIT_W'(mag_raw[c]) > s_q.upper;
      // [RL2] Fine below.
      below_now = LIMIT_W'(mag_raw[c]) < s_q.lower;
      s_d.below[c] = below_now;
      // [RL3] Dwell count.
      if (!below_now) begin
        s_d.below_cnt[c] = '0;
      end else if (s_q.below_cnt[c] != '1) begin
        s_d.below_cnt[c] = s_q.below_cnt[c] + 16'h0001;
      end
      s_d.raise[c] = below_now && (s_d.below_cnt[c] >= s_q.dwell);
      // [RL13] Complex power.
      pw = s_q.monc[MON_CPLX] ? sq_cplx : {1'b0, sq[c]};
      sum_f = s_q.sum[c] + SUM_W'(pw);
      // [RL21] Peak tracking.
      peak_f = (mag_mon[c] > s_q.peak[c]) ? mag_mon[c] : s_q.peak[c];
      thr_f = s_q.thr[c];
      if (LIMIT_W'(mag_mon[c]) > s_q.upper && thr_f != '1) begin
        thr_f = thr_f + 10'h001;
      end
      scaled = sum_f >> per_log;
      ms = (|scaled[SUM_W-1:RESULT_W]) ? '1 : scaled[RESULT_W-1:0];
      // [RL14] Root or mean square.
      pow = s_q.monc[MON_MS] ? ms : RESULT_W'(isqrt(ms));
      // [RL16] Enable gates monitor; sync or period end restarts.
      if (!s_q.monc[MON_EN] || sync_go || last) begin
        s_d.sum[c] = '0;
        s_d.peak[c] = '0;
        s_d.thr[c] = '0;
      end else begin
        s_d.sum[c] = sum_f;
        s_d.peak[c] = peak_f;
        s_d.thr[c] = thr_f;
      end
      // [RL20] Period end update.
      if (s_q.monc[MON_EN] && !sync_go && last) begin
        s_d.pow_snap[c] = pow;
        s_d.peak_snap[c] = peak_f;
        s_d.thr_snap[c] = thr_f;
        // [RL15] Result mode select.
        if (s_q.monc[2:1] == MODE_POWER) begin
          s_d.result[c] = pow;
        end else if (s_q.monc[2:1] == MODE_PEAK) begin
          s_d.result[c] = RESULT_W'(peak_f);
        end else begin
          s_d.result[c] = RESULT_W'(thr_f);
        end
      end
    end
    // Period counter and serial queue sequencer.
    if (!s_q.monc[MON_EN] || sync_go || last) begin
      s_d.cnt = '0;
    end else begin
      s_d.cnt = s_q.cnt + PERIOD_ONE;
    end
    // A full queue stalls the sequencer rather than dropping words.
    if (s_q.pushing && (!push_en || fill_if.ready)) begin
      s_d.idx = s_q.idx + 3'h1;
      s_d.pushing = (s_q.idx != LAST_IDX);
    end
    // [RL12] Queue when enabled.
    if (s_q.monc[MON_EN] && !sync_go && last && s_q.serc[SER_EN]) begin
      s_d.pushing = 1'b1;
      s_d.idx = '0;
    end
  end

  // State register with documented reset values.
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      s_q <= '0;
      s_q.serc <= SERC_RST;
      s_q.monc <= MONC_RST;
      s_q.period <= PERIOD_RST;
    end else begin
      s_q <= s_d;
    end
  end
  assign reg_rdata = s_q.rdata;
  assign data_a = s_q.out[0];
  assign data_b = s_q.out[1];
  assign fine_over_flag = s_q.over;
  assign fine_below_flag = s_q.below;
  assign gain_raise_flag = s_q.raise;
  // Result words wait here while the slow serial clock drains them.
  stream_fifo #(.WIDTH(WORD_W), .DEPTH(FIFO_DEPTH)) u_fifo (.mclk(mclk),
    .rst_n(rst_n), .wr(fill_if), .rd(drain_if));
  serial_shifter u_shift (.mclk(mclk), .rst_n(rst_n), .src(drain_if),
    .enable(s_q.serc[SER_EN]), .sleep(s_q.serc[SER_SLEEP]),
    .div_code(s_q.serc[3:2]), .sclk(monitor_serial_clock),
    .sdata(monitor_serial_output), .frame(monitor_serial_frame));
endmodule : adc_signal_monitor

// ==== tb/sigmon_rx.sv ====
`timescale 1ns/100ps
module sigmon_rx (
  // Serial pins from the monitor.
  input wire logic sclk,
  input wire logic sdata,
  input wire logic frame
);
  logic [19:0] words [8];
  int n_words = 0;
  // A frame opens a new word; later bits shift in below it.
  // Framed word capture.
  always @(posedge sclk) begin
    if (frame) begin
      n_words = n_words + 1;
    end
    if (n_words > 0 && n_words < 9) begin
      words[n_words-1] = {frame ? 19'h0_0000 : words[n_words-1][18:0], sdata};
    end
  end
endmodule : sigmon_rx

// ==== tb/sigmon_chk.sv ====
`timescale 1ns/100ps
module sigmon_chk
  import sigmon_pkg::*;
#(parameter int FIFO_DEPTH = 16) (
  // Clock and register port.
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [ADDR_W-1:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata,
  // Samples and indications.
  input wire logic [SAMPLE_W-1:0] sample_a,
  input wire logic [SAMPLE_W-1:0] data_a,
  input wire logic [1:0] fine_over_flag,
  input wire logic [1:0] fine_below_flag,
  input wire logic [1:0] gain_raise_flag,
  // Serial pins.
  input wire logic monitor_serial_clock,
  input wire logic monitor_serial_output,
  input wire logic monitor_serial_frame
);
  logic [LIMIT_W-1:0] lim_q;
  logic path_q;
  logic [10:0] mag_a;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);
  // Eleven bits, so that the most negative sample keeps its magnitude.
  assign mag_a = sample_a[9] ? {1'b0, ~sample_a} + 11'h001 : {1'b0, sample_a};
  // Shadow of the upper limit and the path correction bit.
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      lim_q <= '0;
      path_q <= 1'b0;
    end else if (reg_wr && reg_addr == A_UPPER_LO) begin
      lim_q[7:0] <= reg_wdata;
    end else if (reg_wr && reg_addr == A_UPPER_HI) begin
      lim_q[12:8] <= reg_wdata[4:0];
    end else if (reg_wr && reg_addr == A_DCC) begin
      path_q <= reg_wdata[DCC_PATH];
    end
  end
  // The high phase of the serial clock lasts at most four cycles.
  sequence sclk_falls;
    ##[1:4] $fell(monitor_serial_clock);
  endsequence
  chk_over_mag: assert property ($past(rst_n) |->
    fine_over_flag[0] == ($past(mag_a) > $past(lim_q)))
    else $error("fine over flag wrong");
  chk_gain_below: assert property (gain_raise_flag[0] |->
    fine_below_flag[0]) else $error("gain flag without below");
  chk_path_off: assert property ($past(rst_n) && !$past(path_q) |->
    data_a == $past(sample_a)) else $error("data path altered");
  chk_rdata_hold: assert property (!$past(reg_rd) |->
    $stable(reg_rdata)) else $error("read data moved");
  chk_resv_nibble: assert property ($past(reg_rd) &&
    $past(reg_addr) == A_RESA2 |-> reg_rdata[7:4] == 4'h0)
    else $error("reserved result bits set");
  chk_sclk_high: assert property ($rose(monitor_serial_clock) |->
    sclk_falls) else $error("serial clock high too long");
  chk_data_low: assert property ($changed(monitor_serial_output) |->
    !monitor_serial_clock) else $error("data moved with clock high");
  chk_frame_low: assert property ($rose(monitor_serial_frame) |->
    !monitor_serial_clock) else $error("word start with clock high");
endmodule : sigmon_chk
bind adc_signal_monitor sigmon_chk #(.FIFO_DEPTH(FIFO_DEPTH)) sigmon_chk_inst (
  .mclk, .rst_n, .reg_wr, .reg_rd, .reg_addr, .reg_wdata, .reg_rdata,
  .sample_a, .data_a, .fine_over_flag, .fine_below_flag, .gain_raise_flag,
  .monitor_serial_clock, .monitor_serial_output, .monitor_serial_frame);

// ==== tb/tb.sv ====
`timescale 1ns/100ps
module tb
  import sigmon_pkg::*;
;
  logic mclk, rst_n, reg_wr, reg_rd, sync_off;
  logic [SAMPLE_W-1:0] sample_a, sample_b, data_a;
  logic [ADDR_W-1:0] reg_addr;
  logic [7:0] reg_wdata, reg_rdata, d;
  logic [1:0] fine_over_flag, fine_below_flag, gain_raise_flag;
  logic monitor_serial_clock, monitor_serial_output, monitor_serial_frame;
  int n_errors = 0;
  int num_checks = 0;
  int cyc = 0;
  // Register rows: write flag, address, write data, expected read.
  logic [25:0] rows [13] = '{
    {1'b0, A_SERC, 8'h00, 8'h04}, {1'b0, A_MONC, 8'h00, 8'h00},
    {1'b0, A_PER0, 8'h00, 8'h40}, {1'b0, A_PER1, 8'h00, 8'h00},
    {1'b0, 9'h11c, 8'h00, 8'h00}, {1'b1, 9'h11c, 8'hff, 8'h00},
    {1'b1, A_UPPER_HI, 8'hff, 8'h1f}, {1'b1, A_DCC, 8'hff, 8'h7f},
    {1'b1, A_MONC, 8'hff, 8'h8f}, {1'b1, A_DCC, 8'h00, 8'h00},
    {1'b1, A_MONC, 8'h00, 8'h00}, {1'b1, A_DCA_HI, 8'hff, 8'h00},
    {1'b1, A_UPPER_HI, 8'h01, 8'h01}};
  // Sample against the limit 0x100, beside the expected over flag.
  logic [10:0] frows [4] = '{{10'h100, 1'b0}, {10'h101, 1'b1},
    {10'h2ff, 1'b1}, {10'h300, 1'b0}};
  adc_signal_monitor #(.FIFO_DEPTH(16)) adc_signal_monitor_inst (.mclk,
    .rst_n, .sample_a, .sample_b, .sync_pulse(sync_off),
    .monitor_sync_en(sync_off), .master_sync_en(sync_off), .reg_wr, .reg_rd,
    .reg_addr, .reg_wdata, .reg_rdata, .data_a, .data_b(), .fine_over_flag,
    .fine_below_flag, .gain_raise_flag, .monitor_serial_clock,
    .monitor_serial_output, .monitor_serial_frame);
  sigmon_rx sigmon_rx_inst (.sclk(monitor_serial_clock),
    .sdata(monitor_serial_output), .frame(monitor_serial_frame));
  // Clock, and a cycle ceiling well above the expected run.
  always #2 mclk = ~mclk;
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 5000) begin
      n_errors++;
      stop_test();
    end
  end
  task automatic chk(input string what, input logic [19:0] e, logic [19:0] g);
    num_checks++;
    if (g !== e) begin
      n_errors++;
      $display("[ERR] %s expected %h seen %h", what, e, g);
    end
  endtask : chk
  task automatic wr(input logic [8:0] a, input logic [7:0] v);
    @(posedge mclk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= v;
    @(posedge mclk);
    reg_wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [8:0] a, output logic [7:0] v);
    @(posedge mclk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge mclk);
    reg_rd <= 1'b0;
    #1 v = reg_rdata;
  endtask : rd
  task automatic stop_test();
    $display("checks %0d mismatches %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : stop_test
  // Main sequence: reset, register table, then hand-written cases.
  initial begin
    {mclk, rst_n, reg_wr, reg_rd, sync_off, reg_addr, reg_wdata} = '0;
    {sample_a, sample_b} = '0;
    repeat (10) @(posedge mclk);
    rst_n <= 1'b1;
    foreach (rows[i]) begin
      if (rows[i][25]) begin
        wr(rows[i][24:16], rows[i][15:8]);
      end
      rd(rows[i][24:16], d);
      chk("register", rows[i][7:0], d);
    end
    $display("register table done");
    foreach (frows[i]) begin
      @(posedge mclk);
      sample_a <= frows[i][10:1];
      @(posedge mclk);
      #1 chk("over flag", frows[i][0], fine_over_flag[0]);
      chk("data a", frows[i][10:1], data_a);
    end
    $display("fine limit done");
    // Peak mode over 128 cycles, results sent with sleep and divide by 2.
    // Minimum period.
    wr(A_PER0, 8'h80);
    @(posedge mclk);
    sample_a <= 10'h040;
    sample_b <= 10'h3d0;
    wr(A_SERC, 8'h27);
    wr(A_MONC, 8'h03);
    repeat (300) @(posedge mclk);
    rd(A_RESA0, d);
    chk("peak a", 20'h0_0040, d);
    rd(A_RESB0, d);
    chk("peak b", 20'h0_0030, d);
    chk("word a", 20'h0_0040, sigmon_rx_inst.words[0]);
    chk("word b", 20'h0_0030, sigmon_rx_inst.words[1]);
    $display("peak serial done");
    // Dwell of five cycles below a lower limit of 0x10.
    wr(A_LOWER_LO, 8'h10);
    wr(A_DWELL_LO, 8'h05);
    @(posedge mclk);
    sample_a <= 10'h000;
    repeat (3) @(posedge mclk);
    #1 chk("gain early", 20'h0_0000, gain_raise_flag[0]);
    chk("below", 20'h0_0001, fine_below_flag[0]);
    repeat (3) @(posedge mclk);
    #1 chk("gain late", 20'h0_0001, gain_raise_flag[0]);
    $display("dwell done");
    stop_test();
  end
endmodule : tb
